/* include/dtp_pkg.sv */
package dtp_pkg;

    // ==========================================================
    // Register map: printed offsets are indices, byte address = 4 * index
    localparam int unsigned AXI_AW = 8;
    localparam int unsigned ADDR_LSB = 2;
    localparam int unsigned IDX_W = 6;
    localparam logic [IDX_W-1:0] IDX_TA_CTRL = 6'h1c;
    localparam logic [IDX_W-1:0] IDX_TA_COUNT = 6'h1d;
    localparam logic [IDX_W-1:0] IDX_TA_SCALE = 6'h1e;
    localparam logic [IDX_W-1:0] IDX_TB_CTRL = 6'h32;
    localparam logic [IDX_W-1:0] IDX_TB_COUNT = 6'h33;
    localparam logic [IDX_W-1:0] IDX_TB_SCALE = 6'h34;
    localparam logic [IDX_W-1:0] IDX_TB_LIMIT = 6'h3f;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Field layout and reset values
    localparam int unsigned CS_HI = 7;
    localparam int unsigned CS_LO = 4;
    localparam int unsigned OS_HI = 3;
    localparam int unsigned OS_LO = 2;
    localparam int unsigned MODE_BIT = 1;
    localparam int unsigned INV_BIT = 0;
    localparam int unsigned RES_BIT = 7;
    localparam int unsigned PRE_HI = 6;
    localparam int unsigned PRE_LO = 5;
    localparam int unsigned SCL_HI = 4;
    localparam int unsigned SCL_LO = 0;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [7:0] FULL_TOP = 8'hff;

    // ==========================================================
    // Clock select codes
    typedef enum logic [3:0] {
        DTP_CS_OFF = 4'h0,
        DTP_CS_SYS = 4'h1,
        DTP_CS_FAST = 4'h2,
        DTP_CS_EXT = 4'h3,
        DTP_CS_SLOW = 4'h4,
        DTP_CS_CMP = 4'h5,
        DTP_CS_A0_RISE = 4'h8,
        DTP_CS_A0_FALL = 4'h9,
        DTP_CS_B0_RISE = 4'ha,
        DTP_CS_B0_FALL = 4'hb,
        DTP_CS_A4_RISE = 4'hc,
        DTP_CS_A4_FALL = 4'hd
    } dtp_csel_t;

    // Output select codes
    localparam logic [1:0] OSEL_OFF = 2'h0;
    localparam logic [1:0] OSEL_1 = 2'h1;
    localparam logic [1:0] OSEL_2 = 2'h2;
    localparam logic [1:0] OSEL_3 = 2'h3;

    // Positions of the synchronised clock sources
    localparam int unsigned NUM_SRC = 7;
    localparam int unsigned SRC_FAST = 0;
    localparam int unsigned SRC_SLOW = 1;
    localparam int unsigned SRC_EXT = 2;
    localparam int unsigned SRC_CMP = 3;
    localparam int unsigned SRC_A0 = 4;
    localparam int unsigned SRC_B0 = 5;
    localparam int unsigned SRC_A4 = 6;

    // Prescaler terminal counts for divide by 1, 4, 16, 64
    function automatic logic [5:0] pre_limit(input logic [1:0] sel);
        logic [5:0] lim;
        lim = 6'h00;
        case (sel)
            2'h1: lim = 6'h03;
            2'h2: lim = 6'h0f;
            2'h3: lim = 6'h3f;
            default: lim = 6'h00;
        endcase
        return lim;
    endfunction

    // One-hot pin enable from an output select field
    function automatic logic [2:0] osel_dec(input logic [1:0] sel);
        logic [2:0] en;
        en = 3'h0;
        case (sel)
            OSEL_1: en = 3'h1;
            OSEL_2: en = 3'h2;
            OSEL_3: en = 3'h4;
            default: en = 3'h0;
        endcase
        return en;
    endfunction

endpackage

/* include/dtp_timer_if.sv */
interface dtp_timer_if;
    logic [7:0] ctrl;
    logic [7:0] scale;
    logic [7:0] bound;
    logic load;
    logic [7:0] load_val;
    logic [7:0] count;
    logic wave;

    modport regs (
        output ctrl, scale, bound, load, load_val,
        input count, wave
    );
    modport tmr (
        input ctrl, scale, bound, load, load_val,
        output count, wave
    );
endinterface

/* src/dtp_pin_sync.sv */
module dtp_pin_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pins
    input wire logic [W-1:0] pin_async,
    output logic [W-1:0] pin_level
);
    import dtp_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } dtp_sync_st_t;

    dtp_sync_st_t q_r;
    dtp_sync_st_t q_nxt;

    // A change is accepted only once the two settled stages agree
    always_comb
    begin
        q_nxt = q_r;
        q_nxt.s1 = pin_async;
        q_nxt.s2 = q_r.s1;
        q_nxt.s3 = q_r.s2;
        for (int i = 0; i < int'(W); i++)
        begin
            if (q_r.s2[i] == q_r.s3[i])
            begin
                q_nxt.lvl[i] = q_r.s3[i];
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q_r <= '0;
        end
        else
        begin
            q_r <= q_nxt;
        end
    end

    assign pin_level = q_r.lvl;
endmodule

/* src/dtp_timer.sv */
module dtp_timer #(
    parameter bit FAST_DOUBLE = 1'b0,
    parameter int unsigned REDUCED_BITS = 6
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Synchronised clock sources
    input wire logic [dtp_pkg::NUM_SRC-1:0] src_lvl,
    // Register side
    dtp_timer_if.tmr tif
);
    import dtp_pkg::*;

    typedef struct packed {
        logic [NUM_SRC-1:0] prev;
        logic [5:0] pre_cnt;
        logic [4:0] sc_cnt;
        logic [7:0] cnt;
        logic wave;
    } dtp_tmr_st_t;

    localparam logic [7:0] RED_TOP = 8'((1 << REDUCED_BITS) - 1);

    dtp_tmr_st_t q_r;
    dtp_tmr_st_t q_nxt;

    // Sources are sampled on aclk and a level needs two equal samples, so each must run at most a quarter of it
    function automatic logic src_tick(input logic [3:0] sel, input logic [NUM_SRC-1:0] lvl,
                                      input logic [NUM_SRC-1:0] prv);
        logic [NUM_SRC-1:0] rise;
        logic [NUM_SRC-1:0] fall;
        logic t;
        rise = lvl & ~prv;
        fall = ~lvl & prv;
        t = 1'b0;
        case (sel)
            DTP_CS_SYS: t = 1'b1;
            DTP_CS_FAST: t = FAST_DOUBLE ? (rise[SRC_FAST] | fall[SRC_FAST]) : rise[SRC_FAST];
            DTP_CS_EXT: t = rise[SRC_EXT];
            DTP_CS_SLOW: t = rise[SRC_SLOW];
            DTP_CS_CMP: t = rise[SRC_CMP];
            DTP_CS_A0_RISE: t = rise[SRC_A0];
            DTP_CS_A0_FALL: t = fall[SRC_A0];
            DTP_CS_B0_RISE: t = rise[SRC_B0];
            DTP_CS_B0_FALL: t = fall[SRC_B0];
            DTP_CS_A4_RISE: t = rise[SRC_A4];
            DTP_CS_A4_FALL: t = fall[SRC_A4];
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    always_comb
    begin
        logic tick;
        logic ptick;
        logic ctick;
        logic [7:0] top;
        logic [7:0] duty;
        tick = src_tick(tif.ctrl[CS_HI:CS_LO], src_lvl, q_r.prev);
        ptick = 1'b0;
        ctick = 1'b0;
        top = tif.scale[RES_BIT] ? RED_TOP : FULL_TOP;
        duty = tif.bound & top;
        q_nxt = q_r;
        q_nxt.prev = src_lvl;
        if (tick)
        begin
            if (q_r.pre_cnt >= pre_limit(tif.scale[PRE_HI:PRE_LO]))
            begin
                q_nxt.pre_cnt = '0;
                ptick = 1'b1;
            end
            else
            begin
                q_nxt.pre_cnt = q_r.pre_cnt + 6'h01;
            end
        end
        if (ptick)
        begin
            if (q_r.sc_cnt >= tif.scale[SCL_HI:SCL_LO])
            begin
                q_nxt.sc_cnt = '0;
                ctick = 1'b1;
            end
            else
            begin
                q_nxt.sc_cnt = q_r.sc_cnt + 5'h01;
            end
        end
        // A software load beats a count in the same cycle
        if (tif.load)
        begin
            q_nxt.cnt = tif.load_val;
        end
        else if (ctick)
        begin
            if (tif.ctrl[MODE_BIT])
            begin
                q_nxt.cnt = (q_r.cnt >= top) ? CNT_RST : q_r.cnt + 8'h01;
            end
            else if (q_r.cnt == tif.bound)
            begin
                q_nxt.cnt = CNT_RST;
                q_nxt.wave = ~q_r.wave;
            end
            else
            begin
                q_nxt.cnt = q_r.cnt + 8'h01;
            end
        end
        if (tif.ctrl[MODE_BIT])
        begin
            q_nxt.wave = (q_nxt.cnt < duty);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q_r <= '0;
        end
        else
        begin
            q_r <= q_nxt;
        end
    end

    assign tif.count = q_r.cnt;
    assign tif.wave = q_r.wave;
endmodule

/* src/dtp_top.sv */
// Register access over AXI4-Lite is this design's own decision.
module dtp_top #(
    // Fast oscillator counted on both edges (doubled rate)
    parameter bit FAST_DOUBLE = 1'b0,
    // Resolution used when scaler bit 7 is set: 6 or 7
    parameter int unsigned REDUCED_BITS = 6,
    // Output code 01 of timer_a: 0 port_b_pin_two, 1 port_b_pin_zero
    parameter bit PIN_OPTION = 1'b0,
    // Fixed terminal value of timer_a when not in PWM mode; in PWM mode it sets the duty value
    parameter logic [7:0] TA_BOUND = 8'hff
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [dtp_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [dtp_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Clock sources, asynchronous
    input wire logic fast_internal_osc,
    input wire logic slow_internal_osc,
    input wire logic external_crystal_osc,
    input wire logic comparator_out,
    input wire logic port_a_pin_zero_in,
    input wire logic port_b_pin_zero_in,
    input wire logic port_a_pin_four_in,
    // timer_a pins: [0] b2, [1] b0, [2] a3, [3] b4
    output logic [3:0] timer_a_pin_o,
    output logic [3:0] timer_a_pin_oe,
    // timer_b pins: [0] b5, [1] b6, [2] b7
    output logic [2:0] timer_b_pin_o,
    output logic [2:0] timer_b_pin_oe
);
    import dtp_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        logic aw_held;
        logic [IDX_W-1:0] aw_idx;
        logic w_held;
        logic [7:0] w_data;
        logic w_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [7:0] ta_ctrl;
        logic [7:0] ta_scale;
        logic ta_load;
        logic [7:0] tb_ctrl;
        logic [7:0] tb_scale;
        logic [7:0] tb_limit;
        logic tb_load;
        logic [7:0] ld_val;
        logic [3:0] ta_o;
        logic [3:0] ta_oe;
        logic [2:0] tb_o;
        logic [2:0] tb_oe;
    } dtp_top_st_t;

    dtp_top_st_t q_r;
    dtp_top_st_t q_nxt;

    logic [NUM_SRC-1:0] src_lvl;

    dtp_timer_if ta_if();
    dtp_timer_if tb_if();

    // ==========================================================
    // Source synchroniser and the two timers
    dtp_pin_sync #(
        .W(NUM_SRC)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_async({port_a_pin_four_in, port_b_pin_zero_in, port_a_pin_zero_in,
                    comparator_out, external_crystal_osc, slow_internal_osc,
                    fast_internal_osc}),
        .pin_level(src_lvl)
    );

    dtp_timer #(
        .FAST_DOUBLE(FAST_DOUBLE),
        .REDUCED_BITS(REDUCED_BITS)
    ) u_timer_a (
        .aclk(aclk),
        .aresetn(aresetn),
        .src_lvl(src_lvl),
        .tif(ta_if.tmr)
    );

    dtp_timer #(
        .FAST_DOUBLE(FAST_DOUBLE),
        .REDUCED_BITS(REDUCED_BITS)
    ) u_timer_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .src_lvl(src_lvl),
        .tif(tb_if.tmr)
    );

    assign ta_if.ctrl = q_r.ta_ctrl;
    assign ta_if.scale = q_r.ta_scale;
    assign ta_if.bound = TA_BOUND;
    assign ta_if.load = q_r.ta_load;
    assign ta_if.load_val = q_r.ld_val;
    assign tb_if.ctrl = q_r.tb_ctrl;
    assign tb_if.scale = q_r.tb_scale;
    assign tb_if.bound = q_r.tb_limit;
    assign tb_if.load = q_r.tb_load;
    assign tb_if.load_val = q_r.ld_val;

    // ==========================================================
    // Register decode
    function automatic logic idx_known(input logic [IDX_W-1:0] idx);
        return idx inside {IDX_TA_CTRL, IDX_TA_COUNT, IDX_TA_SCALE, IDX_TB_CTRL,
                           IDX_TB_COUNT, IDX_TB_SCALE, IDX_TB_LIMIT};
    endfunction

    function automatic logic [IDX_W-1:0] addr_idx(input logic [AXI_AW-1:0] a);
        return a[ADDR_LSB +: IDX_W];
    endfunction

    always_comb
    begin
        logic [7:0] rd;
        logic [2:0] en_a;
        logic [2:0] en_b;
        logic wave_a;
        logic wave_b;
        rd = 8'h00;
        en_a = 3'h0;
        en_b = 3'h0;
        wave_a = 1'b0;
        wave_b = 1'b0;
        q_nxt = q_r;
        q_nxt.ta_load = 1'b0;
        q_nxt.tb_load = 1'b0;

        // Write channel: address and data taken in either order
        if (q_r.bvalid && s_axi_bready)
        begin
            q_nxt.bvalid = 1'b0;
        end
        if (s_axi_awvalid && q_r.awready)
        begin
            q_nxt.aw_held = 1'b1;
            q_nxt.aw_idx = addr_idx(s_axi_awaddr);
        end
        if (s_axi_wvalid && q_r.wready)
        begin
            q_nxt.w_held = 1'b1;
            q_nxt.w_data = s_axi_wdata[7:0];
            q_nxt.w_lane0 = s_axi_wstrb[0];
        end
        if (q_nxt.aw_held && q_nxt.w_held && !q_r.bvalid)
        begin
            q_nxt.aw_held = 1'b0;
            q_nxt.w_held = 1'b0;
            q_nxt.bvalid = 1'b1;
            q_nxt.bresp = idx_known(q_nxt.aw_idx) ? RESP_OKAY : RESP_SLVERR;
            if (q_nxt.w_lane0)
            begin
                case (q_nxt.aw_idx)
                    IDX_TA_CTRL: q_nxt.ta_ctrl = q_nxt.w_data;
                    IDX_TA_SCALE: q_nxt.ta_scale = q_nxt.w_data;
                    IDX_TB_CTRL: q_nxt.tb_ctrl = q_nxt.w_data;
                    IDX_TB_SCALE: q_nxt.tb_scale = q_nxt.w_data;
                    IDX_TB_LIMIT: q_nxt.tb_limit = q_nxt.w_data;
                    IDX_TA_COUNT:
                    begin
                        q_nxt.ta_load = 1'b1;
                        q_nxt.ld_val = q_nxt.w_data;
                    end
                    IDX_TB_COUNT:
                    begin
                        q_nxt.tb_load = 1'b1;
                        q_nxt.ld_val = q_nxt.w_data;
                    end
                    default: q_nxt.bresp = RESP_SLVERR;
                endcase
            end
        end
        // One write in flight: hold off both channels until the response is taken
        q_nxt.awready = !q_nxt.aw_held && !q_nxt.bvalid;
        q_nxt.wready = !q_nxt.w_held && !q_nxt.bvalid;

        // Read channel; write-only registers read as zero
        if (q_r.rvalid && s_axi_rready)
        begin
            q_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q_r.arready)
        begin
            case (addr_idx(s_axi_araddr))
                IDX_TA_CTRL: rd = q_r.ta_ctrl;
                IDX_TA_COUNT: rd = ta_if.count;
                IDX_TB_CTRL: rd = q_r.tb_ctrl;
                IDX_TB_COUNT: rd = tb_if.count;
                default: rd = 8'h00;
            endcase
            q_nxt.rvalid = 1'b1;
            q_nxt.rdata = rd;
            q_nxt.rresp = idx_known(addr_idx(s_axi_araddr)) ? RESP_OKAY : RESP_SLVERR;
        end
        q_nxt.arready = !q_nxt.rvalid;

        // Output routing, registered so the pins never glitch on decode
        en_a = osel_dec(q_r.ta_ctrl[OS_HI:OS_LO]);
        en_b = osel_dec(q_r.tb_ctrl[OS_HI:OS_LO]);
        wave_a = ta_if.wave ^ q_r.ta_ctrl[INV_BIT];
        wave_b = tb_if.wave ^ q_r.tb_ctrl[INV_BIT];
        q_nxt.ta_oe = {en_a[2], en_a[1], en_a[0] & PIN_OPTION, en_a[0] & ~PIN_OPTION};
        q_nxt.ta_o = q_nxt.ta_oe & {4{wave_a}};
        q_nxt.tb_oe = en_b;
        q_nxt.tb_o = en_b & {3{wave_b}};
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q_r <= '0;
        end
        else
        begin
            q_r <= q_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign s_axi_awready = q_r.awready;
    assign s_axi_wready = q_r.wready;
    assign s_axi_bvalid = q_r.bvalid;
    assign s_axi_bresp = q_r.bresp;
    assign s_axi_arready = q_r.arready;
    assign s_axi_rvalid = q_r.rvalid;
    assign s_axi_rdata = {24'h000000, q_r.rdata};
    assign s_axi_rresp = q_r.rresp;
    assign timer_a_pin_o = q_r.ta_o;
    assign timer_a_pin_oe = q_r.ta_oe;
    assign timer_b_pin_o = q_r.tb_o;
    assign timer_b_pin_oe = q_r.tb_oe;
endmodule

/* verification/dtp_top_sva.sv */
module dtp_top_sva (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Timer pins
    input wire logic [3:0] timer_a_pin_o,
    input wire logic [3:0] timer_a_pin_oe,
    input wire logic [2:0] timer_b_pin_o,
    input wire logic [2:0] timer_b_pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ====================
    // Register bus
    property p_b_done;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready;
    endproperty
    a_b_done: assert property (p_b_done) else $error("write not closed");
    property p_r_done;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
    endproperty
    a_r_done: assert property (p_r_done) else $error("read not closed");
    property p_r_ans;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_ans: assert property (p_r_ans) else $error("read answer late");
    property p_r_upper;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
    endproperty
    a_r_upper: assert property (p_r_upper) else $error("read upper bits set");

    // ====================
    // Output pins
    property p_a_gate;
        (timer_a_pin_o & ~timer_a_pin_oe) == 4'h0;
    endproperty
    a_a_gate: assert property (p_a_gate) else $error("timer_a drives idle pin");
    property p_b_gate;
        (timer_b_pin_o & ~timer_b_pin_oe) == 3'h0;
    endproperty
    a_b_gate: assert property (p_b_gate) else $error("timer_b drives idle pin");
    property p_a_one;
        $onehot0(timer_a_pin_oe);
    endproperty
    a_a_one: assert property (p_a_one) else $error("timer_a on two pins");
    property p_b_one;
        $onehot0(timer_b_pin_oe);
    endproperty
    a_b_one: assert property (p_b_one) else $error("timer_b on two pins");

    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_b_high: cover property (|timer_b_pin_o);
endmodule

bind dtp_top dtp_top_sva dtp_top_sva_inst (
    .aclk, .aresetn, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .timer_a_pin_o,
    .timer_a_pin_oe, .timer_b_pin_o, .timer_b_pin_oe
);

/* verification/dual_8bit_timer_pwm_tb_top.sv */
module dual_8bit_timer_pwm_tb_top import dtp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [5:0] idx; logic [7:0] wd; logic [7:0] rd; logic [1:0] rs;} dtp_row_t;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    // Sources: fast, ext, slow, comparator, a0, b0, a4
    logic [6:0] src = 7'h0;
    logic [3:0] ao, aoe;
    logic [2:0] bo, boe;
    int fails = 0;
    int checked = 0;
    dtp_row_t rows [8] = '{'{IDX_TA_CTRL, 8'h0e, 8'h0e, RESP_OKAY},
        '{IDX_TA_COUNT, 8'h5a, 8'h5a, RESP_OKAY}, '{IDX_TA_SCALE, 8'h1f, 8'h00, RESP_OKAY},
        '{IDX_TB_CTRL, 8'h07, 8'h07, RESP_OKAY}, '{IDX_TB_COUNT, 8'hc3, 8'hc3, RESP_OKAY},
        '{IDX_TB_SCALE, 8'h7f, 8'h00, RESP_OKAY}, '{IDX_TB_LIMIT, 8'h81, 8'h00, RESP_OKAY},
        '{6'h20, 8'h55, 8'h00, RESP_SLVERR}};
    logic [7:0] sc [5] = '{8'h00, 8'h20, 8'h41, 8'h60, 8'h1f};
    int dv [5] = '{1, 4, 32, 64, 32};

    dtp_top dtp_top_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .fast_internal_osc(src[0]), .external_crystal_osc(src[1]),
        .slow_internal_osc(src[2]), .comparator_out(src[3]), .port_a_pin_zero_in(src[4]),
        .port_b_pin_zero_in(src[5]), .port_a_pin_four_in(src[6]), .timer_a_pin_o(ao),
        .timer_a_pin_oe(aoe), .timer_b_pin_o(bo), .timer_b_pin_oe(boe)
    );

    initial
    begin
        forever #2.5 aclk = ~aclk;
    end

    // ====================
    // Checking and bus tasks
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic timeout();
        fails++;
        $display("Error at %0t: wait timed out", $time);
        final_report();
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d, output logic [1:0] rs);
        int n;
        @(posedge aclk);
        awaddr <= {idx, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge aclk);
            if (awvalid && awready === 1'h1) awvalid <= 1'h0;
            if (wvalid && wready === 1'h1) wvalid <= 1'h0;
            if (bvalid === 1'h1) break;
        end
        if (n == 100) timeout();
        rs = bresp;
        bready <= 1'h0;
    endtask

    task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] rs);
        int n;
        @(posedge aclk);
        araddr <= {idx, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge aclk);
            if (arvalid && arready === 1'h1) arvalid <= 1'h0;
            if (rvalid === 1'h1) break;
        end
        if (n == 100) timeout();
        d = rdata;
        rs = rresp;
        rready <= 1'h0;
    endtask

    // High cycles of both outputs and toggles of timer_b over 256 cycles
    task automatic measure(output int ha, output int hb, output int chg);
        logic last;
        ha = 0;
        hb = 0;
        chg = 0;
        last = bo[0];
        repeat (256)
        begin
            @(posedge aclk);
            ha += ao[0];
            hb += bo[0];
            chg += (bo[0] != last);
            last = bo[0];
        end
    endtask

    // Each source j sees j+2 rising edges and ends high, so j+1 falling edges
    function automatic logic [7:0] exp_cnt(input logic [3:0] c);
        if (c >= 4'h2 && c <= 4'h5) return {4'h0, c};
        if (c >= 4'h8) return 8'h6 + 8'((c - 4'h8) >> 1) - 8'(c[0]);
        return 8'h0;
    endfunction

    // ====================
    // Main sequence
    initial
    begin
        logic [31:0] d, rf;
        logic [1:0] r;
        logic [3:0] e, ea;
        int ha, hb, chg;
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (3) @(posedge aclk);
        foreach (rows[i])
        begin
            wr(rows[i].idx, rows[i].wd, r);
            check(32'(r), 32'(rows[i].rs));
            rd(rows[i].idx, d, r);
            check(d, 32'(rows[i].rd));
            check(32'(r), 32'(rows[i].rs));
        end
        repeat (3) @(posedge aclk);
        check({ao, aoe, bo, boe}, 32'h2209);
        // Stopped timers in PWM with count 0 hold their output high
        wr(IDX_TA_COUNT, 8'h00, r);
        wr(IDX_TB_COUNT, 8'h00, r);
        for (int k = 0; k < 8; k++)
        begin
            wr(IDX_TA_CTRL, {4'h0, k[2:1], 1'h1, k[0]}, r);
            wr(IDX_TB_CTRL, {4'h0, k[2:1], 1'h1, k[0]}, r);
            repeat (3) @(posedge aclk);
            e = (k[2:1] == 2'h0) ? 4'h0 : 4'h1 << (k[2:1] - 2'h1);
            // timer_a pin 1 is the alternate of code 01, so codes 10 and 11 sit one higher
            ea = {e[2:1], 1'h0, e[0]};
            check({ao, aoe}, {ea & {4{~k[0]}}, ea});
            check({bo, boe}, {e[2:0] & {3{~k[0]}}, e[2:0]});
        end
        wr(IDX_TB_LIMIT, 8'h50, r);
        wr(IDX_TA_SCALE, 8'h00, r);
        wr(IDX_TB_SCALE, 8'h00, r);
        wr(IDX_TA_CTRL, 8'h16, r);
        wr(IDX_TB_CTRL, 8'h16, r);
        repeat (300) @(posedge aclk);
        measure(ha, hb, chg);
        check(ha, 255);
        check(hb, 80);
        wr(IDX_TA_SCALE, 8'h80, r);
        wr(IDX_TB_SCALE, 8'h80, r);
        repeat (300) @(posedge aclk);
        measure(ha, hb, chg);
        check(hb, 64);
        wr(IDX_TB_LIMIT, 8'h03, r);
        wr(IDX_TB_CTRL, 8'h14, r);
        repeat (300) @(posedge aclk);
        measure(ha, hb, chg);
        check(chg, 64);
        wr(IDX_TB_LIMIT, 8'hff, r);
        for (int k = 0; k < 5; k++)
        begin
            wr(IDX_TB_CTRL, 8'h00, r);
            wr(IDX_TB_SCALE, sc[k], r);
            wr(IDX_TB_COUNT, 8'h00, r);
            wr(IDX_TB_CTRL, 8'h10, r);
            repeat (200) @(posedge aclk);
            wr(IDX_TB_CTRL, 8'h00, r);
            rd(IDX_TB_COUNT, d, r);
            if (k == 0) rf = d;
            check(d * dv[k] <= rf + dv[k] && rf <= d * dv[k] + dv[k], 1);
        end
        wr(IDX_TB_SCALE, 8'h00, r);
        for (int c = 0; c < 14; c++)
        begin
            if (c == 1) continue;
            wr(IDX_TA_CTRL, 8'h00, r);
            wr(IDX_TB_CTRL, 8'h00, r);
            src <= 7'h0;
            wr(IDX_TA_COUNT, 8'h00, r);
            wr(IDX_TB_COUNT, 8'h00, r);
            wr(IDX_TA_CTRL, {c[3:0], 4'h0}, r);
            wr(IDX_TB_CTRL, {c[3:0], 4'h0}, r);
            repeat (8) @(posedge aclk);
            for (int s = 0; s < 16; s++)
            begin
                for (int j = 0; j < 7; j++)
                    src[j] <= (s >= 2 * j + 3) ? 1'h1 : ~s[0];
                repeat (6) @(posedge aclk);
            end
            repeat (10) @(posedge aclk);
            wr(IDX_TA_CTRL, 8'h00, r);
            wr(IDX_TB_CTRL, 8'h00, r);
            rd(IDX_TA_COUNT, d, r);
            check(d, 32'(exp_cnt(c[3:0])));
            rd(IDX_TB_COUNT, d, r);
            check(d, 32'(exp_cnt(c[3:0])));
        end
        // Reset again with timer_b running
        wr(IDX_TB_CTRL, 8'h16, r);
        aresetn <= 1'h0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (3) @(posedge aclk);
        check({ao, aoe, bo, boe}, 32'h0);
        for (int k = 0; k < 4; k++)
        begin
            rd(k[1] ? (k[0] ? IDX_TB_COUNT : IDX_TB_CTRL) : (k[0] ? IDX_TA_COUNT : IDX_TA_CTRL), d, r);
            check(d, 32'h0);
        end
        final_report();
    end
endmodule
